// >>> tb/hbl_decode_test.sv
// Self-checking bench for the load/store decoder
`timescale 1ns/1ps

module hbl_decode_test
   import hbl_pkg::*;
;
   logic         sys_clk, srst, instr_valid, mem_ack, busy, instr_taken, instr_ignored;
   logic         mem_req, mem_we, rf_we, done;
   logic [15:0]  instr;
   logic [31:0]  rf_rdata_base, rf_rdata_ofs, rf_rdata_data, mem_rdata, mem_addr, mem_wdata;
   logic [31:0]  rf_wdata, load_word;
   logic [3:0]   rf_sel_base, rf_sel_ofs, rf_sel_data, rf_waddr, wait_cycles;
   hbl_size_type mem_size;
   logic [31:0]  regs [16];
   int           errors, tests_run, cycles;

   assign rf_rdata_base = regs[rf_sel_base];
   assign rf_rdata_ofs  = regs[rf_sel_ofs];
   assign rf_rdata_data = regs[rf_sel_data];

   hbl_decode dut_u (.sys_clk, .srst, .instr_valid, .instr, .rf_rdata_base, .rf_rdata_ofs,
      .rf_rdata_data, .mem_ack, .mem_rdata, .busy, .instr_taken, .instr_ignored, .rf_sel_base,
      .rf_sel_ofs, .rf_sel_data, .mem_req, .mem_we, .mem_size, .mem_addr, .mem_wdata, .rf_we,
      .rf_waddr, .rf_wdata, .done);

   hbl_mem_model mem_u (.sys_clk, .srst, .mem_req, .mem_size, .load_word, .wait_cycles,
      .mem_ack, .mem_rdata);

   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One transfer; store when e_we, else load result in e_dat
   task automatic op(input logic [15:0] ins, input logic [3:0] wt, input logic [31:0] ld,
      input logic [31:0] e_addr, input logic e_we, input hbl_size_type e_sz,
      input logic [31:0] e_dat, input logic [2:0] rd);
      int           n, t0;
      logic         g_we, seen, bz;
      logic [31:0]  g_addr, g_dat, g_rf;
      logic [3:0]   g_wa;
      hbl_size_type g_sz;
      t0 = -100;
      seen = 1'b0;
      bz = 1'b0;
      {g_we, g_addr, g_dat, g_rf, g_wa} = 'x;
      g_sz = SZ_BYTE;
      @(posedge sys_clk);
      #1;
      wait_cycles = wt;
      load_word = ld;
      instr = ins;
      instr_valid = 1'b1;
      @(posedge sys_clk);
      #1 instr_valid = 1'b0;
      for (n = 0; n < 30; n++)
      begin
         @(negedge sys_clk);
         if (instr_taken)
         begin
            t0 = n;
            bz = busy;
         end
         if (mem_req && mem_ack)
         begin
            g_addr = mem_addr;
            g_we   = mem_we;
            g_sz   = mem_size;
            g_dat  = mem_wdata;
         end
         if (rf_we)
            {seen, g_wa, g_rf} = {1'b1, rf_waddr, rf_wdata};
         if (done)
            break;
      end
      chk(32'(n - t0), 32'(3 + wt));
      chk(32'(bz), 32'h1);
      chk(32'(busy), 32'h0);
      chk(g_addr, e_addr);
      chk(32'(g_we), 32'(e_we));
      chk(32'(g_sz), 32'(e_sz));
      chk(32'(seen), 32'(!e_we));
      if (e_we)
         chk(g_dat, e_dat);
      else
      begin
         chk(32'(g_wa), 32'(rd));
         chk(g_rf, e_dat);
      end
   endtask : op

   task automatic sc_reg_ofs();
      logic [31:0] a;
      a = regs[2] + regs[6];
      op({5'h0a, 2'b01, 9'o624}, 0, 32'h5a3c_80f5, a, 1, SZ_HALF, {16'h0, regs[4][15:0]}, 4);
      op({5'h0a, 2'b11, 9'o625}, 1, 32'h5a3c_80f5, a, 0, SZ_HALF, 32'h0000_80f5, 5);
      op({5'h0b, 2'b01, 9'o623}, 0, 32'h5a3c_80f5, a, 0, SZ_BYTE, 32'hffff_fff5, 3);
      op({5'h0b, 2'b11, 9'o621}, 2, 32'h5a3c_80f5, a, 0, SZ_HALF, 32'hffff_80f5, 1);
      op({5'h0b, 2'b01, 9'o623}, 0, 32'h0000_7f75, a, 0, SZ_BYTE, 32'h0000_0075, 3);
      op({5'h0b, 2'b11, 9'o621}, 0, 32'h0000_7f75, a, 0, SZ_HALF, 32'h0000_7f75, 1);
   endtask : sc_reg_ofs

   task automatic sc_imm();
      op({5'h0c, 5'd31, 6'o52}, 0, 32'h0, regs[5] + 124, 1, SZ_WORD, regs[2], 2);
      op({5'h0d, 5'd29, 6'o52}, 1, 32'h8123_4567, regs[5] + 116, 0, SZ_WORD, 32'h8123_4567, 2);
      op({5'h0e, 5'd13, 6'o01}, 0, 32'h0, regs[0] + 13, 1, SZ_BYTE, {24'h0, regs[1][7:0]}, 1);
      op({5'h0f, 5'd31, 6'o77}, 3, 32'h0000_00e9, regs[7] + 31, 0, SZ_BYTE, 32'h0000_00e9, 7);
   endtask : sc_imm

   task automatic sc_half_imm();
      op({5'h10, 5'd28, 6'o14}, 0, 32'h0, regs[1] + 56, 1, SZ_HALF, {16'h0, regs[4][15:0]}, 4);
      op({5'h11, 5'd31, 6'o77}, 1, 32'hfedc_ba98, regs[7] + 62, 0, SZ_HALF, 32'h0000_ba98, 7);
   endtask : sc_half_imm

   task automatic sc_sp_rel();
      op({5'h12, 3'd4, 8'd123}, 0, 32'h0, regs[13] + 492, 1, SZ_WORD, regs[4], 4);
      op({5'h13, 3'd6, 8'd255}, 2, 32'h89ab_cdef, regs[13] + 1020, 0, SZ_WORD, 32'h89ab_cdef, 6);
   endtask : sc_sp_rel

   task automatic sc_refused();
      int reqs;
      reqs = 0;
      @(posedge sys_clk);
      #1;
      instr = 16'h5000;
      instr_valid = 1'b1;
      @(posedge sys_clk);
      #1 instr_valid = 1'b0;
      @(negedge sys_clk);
      chk(32'(instr_ignored), 32'h1);
      repeat (5)
      begin
         @(negedge sys_clk);
         reqs += int'(mem_req | busy);
      end
      chk(32'(reqs), 32'h0);
   endtask : sc_refused

   initial
   begin
      {errors, tests_run, cycles} = '0;
      srst = 1'b1;
      instr_valid = 1'b0;
      instr = 16'h0;
      load_word = 32'h0;
      wait_cycles = 4'h0;
      for (int i = 0; i < 16; i++)
         regs[i] = 32'hc3a5_8e00 + 32'(i) * 32'h0104_0011;
      repeat (8) @(posedge sys_clk);
      #1 srst = 1'b0;
      sc_reg_ofs();
      sc_imm();
      sc_half_imm();
      sc_sp_rel();
      sc_refused();
      stop_test();
   end
endmodule : hbl_decode_test

// >>> tb/hbl_mem_model.sv
// Data memory model answering the decoder's requests
`timescale 1ns/1ps

module hbl_mem_model
   import hbl_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         srst,
   input  wire logic         mem_req,
   input  wire hbl_size_type mem_size,
   input  wire logic [31:0]  load_word,
   input  wire logic [3:0]   wait_cycles,
   output logic              mem_ack,
   output logic [31:0]       mem_rdata
);
   logic [3:0]  count;
   logic [31:0] sized;

   // Wait states counted from the first request cycle
   always_ff @(posedge sys_clk)
   begin
      if (srst || !mem_req)
         count <= 4'h0;
      else
         count <= count + 4'h1;
   end

   assign mem_ack = mem_req && (count == wait_cycles);

   // Right-justified data, inverted while not valid
   always_comb
   begin
      case (mem_size)
         SZ_BYTE : sized = {24'h0, load_word[7:0]};
         SZ_HALF : sized = {16'h0, load_word[15:0]};
         default : sized = load_word;
      endcase
   end

   assign mem_rdata = mem_ack ? sized : ~sized;
endmodule : hbl_mem_model

// >>> verilog/hbl_decode.sv
// Half-word and byte load/store decode and execute unit
// Summary of operation
// - Register-offset half store writes low sixteen bits at base plus offset.
// - Register-offset half load zero-fills destination bits 16 to 31.
// - Register-offset signed byte load copies byte bit 7 upward.
// - Register-offset signed half load copies half bit 15 upward.
// - Every format takes the same cycle count plus memory wait states, no decode penalty.
// - Immediate word store writes whole register at base plus scaled offset.
// - Immediate word load reads whole word into destination.
// - Word immediate offset is five-bit field shifted left by two.
// - Immediate byte store writes low eight bits at base plus field.
// - Immediate byte load reads byte at base plus unscaled field.
// - Immediate half store writes low sixteen bits at base plus scaled offset.
// - Immediate half load zero-fills destination bits 16 to 31.
// - Half immediate offset is five-bit field shifted left by one.
// - Stack-relative transfers add up to 255 words to stack pointer.
// - Stack word offset field is shifted left by two.
// - Immediate half transfers use low registers, pre-indexed, no write-back.
`timescale 1ns/1ps
`include "hbl_defines.svh"

module hbl_decode
   import hbl_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         srst,
   input  wire logic         instr_valid,
   input  wire logic [15:0]  instr,
   input  wire logic [31:0]  rf_rdata_base,
   input  wire logic [31:0]  rf_rdata_ofs,
   input  wire logic [31:0]  rf_rdata_data,
   input  wire logic         mem_ack,
   input  wire logic [31:0]  mem_rdata,
   output logic              busy,
   output logic              instr_taken,
   output logic              instr_ignored,
   output logic [3:0]        rf_sel_base,
   output logic [3:0]        rf_sel_ofs,
   output logic [3:0]        rf_sel_data,
   output logic              mem_req,
   output logic              mem_we,
   output hbl_size_type      mem_size,
   output logic [31:0]       mem_addr,
   output logic [31:0]       mem_wdata,
   output logic              rf_we,
   output logic [3:0]        rf_waddr,
   output logic [31:0]       rf_wdata,
   output logic              done
);

   hbl_state_type state;
   hbl_kind_type  kind;
   logic          reg_ofs;
   logic [31:0]   imm_ofs;

   logic          next_match;
   logic          next_reg_ofs;
   hbl_kind_type  next_kind;
   logic [31:0]   next_imm;
   logic [3:0]    next_base;
   logic [3:0]    next_ofs;
   logic [3:0]    next_data;
   logic          accept;

   always_comb
   begin
      next_match   = 1'b0;
      next_reg_ofs = 1'b0;
      next_kind    = OP_STW;
      next_imm     = 32'h0;
      next_base    = {1'b0, instr[`HBL_RB_LSB +: 3]};
      next_ofs     = {1'b0, instr[`HBL_RO_LSB +: 3]};
      next_data    = {1'b0, instr[`HBL_RD_LSB +: 3]};
      if (instr[15:12] == `HBL_TOP4_REG_OFS && instr[`HBL_SIGNED_SEL_BIT])
      begin
         next_match   = 1'b1;
         next_reg_ofs = 1'b1;
         unique case ({instr[`HBL_F8_L_BIT], instr[`HBL_F8_B_BIT]})
            2'b00: next_kind = OP_STH;
            2'b01: next_kind = OP_LDH;
            2'b10: next_kind = OP_LDSB;
            2'b11: next_kind = OP_LDSH;
         endcase
      end
      else if (instr[15:13] == `HBL_TOP3_IMM_OFS)
      begin
         next_match = 1'b1;
         unique case ({instr[`HBL_F9_L_BIT], instr[`HBL_F9_B_BIT]})
            2'b00: next_kind = OP_STW;
            2'b10: next_kind = OP_LDW;
            2'b01: next_kind = OP_STB;
            2'b11: next_kind = OP_LDB;
         endcase
         if (!instr[`HBL_F9_B_BIT])
            next_imm = {25'h0, instr[`HBL_OFS5_LSB +: 5], 2'b00};
         else
            next_imm = {27'h0, instr[`HBL_OFS5_LSB +: 5]};
      end
      else if (instr[15:12] == `HBL_TOP4_HALF_IMM)
      begin
         next_match = 1'b1;
         next_kind  = instr[`HBL_F10_L_BIT] ? OP_LDH : OP_STH;
         next_imm   = {26'h0, instr[`HBL_OFS5_LSB +: 5], 1'b0};
      end
      else if (instr[15:12] == `HBL_TOP4_SP_REL)
      begin
         next_match = 1'b1;
         next_kind  = instr[`HBL_F10_L_BIT] ? OP_LDW : OP_STW;
         next_base  = `HBL_SP_INDEX;
         next_data  = {1'b0, instr[`HBL_SP_RD_LSB +: 3]};
         next_imm   = {22'h0, instr[7:0], 2'b00};
      end
   end

   assign accept = instr_valid && (state == ST_IDLE) && next_match;

   // one fixed sequence for every format
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         state <= ST_IDLE;
      else
      begin
         unique case (state)
            ST_IDLE:  if (accept) state <= ST_FETCH;
            ST_FETCH: state <= ST_MEM;
            ST_MEM:   if (mem_ack) state <= ST_WB;
            ST_WB:    state <= ST_IDLE;
         endcase
      end
   end

   // Latch decoded instruction
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         kind        <= OP_STW;
         reg_ofs     <= 1'b0;
         imm_ofs     <= 32'h0;
         rf_sel_base <= 4'h0;
         rf_sel_ofs  <= 4'h0;
         rf_sel_data <= 4'h0;
      end
      else if (accept)
      begin
         kind        <= next_kind;
         reg_ofs     <= next_reg_ofs;
         imm_ofs     <= next_imm;
         rf_sel_base <= next_base;
         rf_sel_ofs  <= next_ofs;
         // transferred register always a low register
         rf_sel_data <= next_data;
      end
   end

   // Handshake status
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         busy          <= 1'b0;
         instr_taken   <= 1'b0;
         instr_ignored <= 1'b0;
         done          <= 1'b0;
      end
      else
      begin
         instr_taken   <= accept;
         instr_ignored <= instr_valid && (state == ST_IDLE) && !next_match;
         done          <= (state == ST_WB);
         if (accept)
            busy <= 1'b1;
         else if (state == ST_WB)
            busy <= 1'b0;
      end
   end

   // Memory request
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_size  <= SZ_WORD;
         mem_addr  <= 32'h0;
         mem_wdata <= 32'h0;
      end
      else if (state == ST_FETCH)
      begin
         mem_req <= 1'b1;
         mem_we  <= (kind == OP_STH) || (kind == OP_STW) || (kind == OP_STB);
         // pre-indexed, base plus offset, no write-back
         mem_addr <= rf_rdata_base + (reg_ofs ? rf_rdata_ofs : imm_ofs);
         unique case (kind)
            OP_STH:
            begin
               mem_size  <= SZ_HALF;
               mem_wdata <= {16'h0, rf_rdata_data[15:0]};
            end
            OP_STB:
            begin
               mem_size  <= SZ_BYTE;
               mem_wdata <= {24'h0, rf_rdata_data[7:0]};
            end
            OP_STW:
            begin
               mem_size  <= SZ_WORD;
               mem_wdata <= rf_rdata_data;
            end
            OP_LDH, OP_LDSH:
            begin
               mem_size  <= SZ_HALF;
               mem_wdata <= 32'h0;
            end
            OP_LDSB, OP_LDB:
            begin
               mem_size  <= SZ_BYTE;
               mem_wdata <= 32'h0;
            end
            OP_LDW:
            begin
               mem_size  <= SZ_WORD;
               mem_wdata <= 32'h0;
            end
         endcase
      end
      else if (state == ST_MEM && mem_ack)
         mem_req <= 1'b0;
   end

   // Load data extension and write-back
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rf_we    <= 1'b0;
         rf_waddr <= 4'h0;
         rf_wdata <= 32'h0;
      end
      else
      begin
         rf_we <= (state == ST_MEM) && mem_ack && !mem_we;
         if (state == ST_MEM && mem_ack)
         begin
            rf_waddr <= rf_sel_data;
            unique case (kind)
               OP_LDH:  rf_wdata <= {16'h0, mem_rdata[15:0]};
               OP_LDSB: rf_wdata <= {{24{mem_rdata[7]}}, mem_rdata[7:0]};
               OP_LDSH: rf_wdata <= {{16{mem_rdata[15]}}, mem_rdata[15:0]};
               OP_LDB:  rf_wdata <= {24'h0, mem_rdata[7:0]};
               default: rf_wdata <= mem_rdata;
            endcase
         end
      end
   end

   // Assertions
   a_store_half_low: assert property (@(posedge sys_clk) disable iff (srst)
      (mem_req && kind == OP_STH) |-> (mem_size == SZ_HALF && mem_wdata == {16'h0, $past(rf_rdata_data[15:0])})
         or $past(mem_req))
      else $error("half store data or size wrong");

   a_reg_ofs_addr: assert property (@(posedge sys_clk) disable iff (srst)
      ($rose(mem_req) && reg_ofs) |-> mem_addr == $past(rf_rdata_base) + $past(rf_rdata_ofs))
      else $error("register offset address wrong");

   a_ldh_zero_fill: assert property (@(posedge sys_clk) disable iff (srst)
      (rf_we && kind == OP_LDH) |-> rf_wdata == {16'h0, $past(mem_rdata[15:0])})
      else $error("half load not zero filled");

   a_ldsb_sign_fill: assert property (@(posedge sys_clk) disable iff (srst)
      (rf_we && kind == OP_LDSB) |-> rf_wdata == {{24{$past(mem_rdata[7])}}, $past(mem_rdata[7:0])})
      else $error("signed byte extension wrong");

   a_ldsh_sign_fill: assert property (@(posedge sys_clk) disable iff (srst)
      (rf_we && kind == OP_LDSH) |-> rf_wdata == {{16{$past(mem_rdata[15])}}, $past(mem_rdata[15:0])})
      else $error("signed half extension wrong");

   a_fixed_latency: assert property (@(posedge sys_clk) disable iff (srst)
      accept |=> !mem_req ##1 $rose(mem_req))
      else $error("request not two cycles after accept");

   a_done_after_ack: assert property (@(posedge sys_clk) disable iff (srst)
      (mem_req && mem_ack) |=> !mem_req ##1 (done && !busy))
      else $error("completion not two cycles after ack");

   a_word_imm_scale: assert property (@(posedge sys_clk) disable iff (srst)
      (mem_req && !reg_ofs && mem_size == SZ_WORD && rf_sel_base != `HBL_SP_INDEX)
         |-> (imm_ofs[1:0] == 2'b00 && imm_ofs <= `HBL_IMM_WORD_MAX))
      else $error("word immediate not scaled");

   a_half_imm_scale: assert property (@(posedge sys_clk) disable iff (srst)
      (mem_req && !reg_ofs && mem_size == SZ_HALF) |-> (imm_ofs[0] == 1'b0 && imm_ofs <= `HBL_IMM_HALF_MAX))
      else $error("half immediate not scaled");

   a_sp_word_ofs: assert property (@(posedge sys_clk) disable iff (srst)
      (mem_req && rf_sel_base == `HBL_SP_INDEX)
         |-> (mem_size == SZ_WORD && imm_ofs[1:0] == 2'b00 && imm_ofs <= `HBL_WORD_OFS_MAX))
      else $error("stack offset out of range");

   a_store_byte_low: assert property (@(posedge sys_clk) disable iff (srst)
      (mem_req && kind == OP_STB) |-> (mem_wdata[31:8] == 24'h0 && mem_size == SZ_BYTE))
      else $error("byte store upper bits set");

   a_ldw_full_word: assert property (@(posedge sys_clk) disable iff (srst)
      (rf_we && kind == OP_LDW) |-> rf_wdata == $past(mem_rdata))
      else $error("word load data wrong");

   a_lo_data_reg: assert property (@(posedge sys_clk) disable iff (srst)
      busy |-> rf_sel_data[3] == 1'b0)
      else $error("data register not low");

   a_imm_addr_sum: assert property (@(posedge sys_clk) disable iff (srst)
      ($rose(mem_req) && !reg_ofs) |-> mem_addr == $past(rf_rdata_base) + imm_ofs)
      else $error("immediate offset address wrong");

   a_req_held_wait: assert property (@(posedge sys_clk) disable iff (srst)
      (mem_req && !mem_ack) |=> (mem_req && $stable(mem_addr) && $stable(mem_wdata)))
      else $error("request dropped before ack");

   a_ignored_idle: assert property (@(posedge sys_clk) disable iff (srst)
      instr_ignored |-> (!busy && !mem_req))
      else $error("ignored instruction started");

   c_ldsh_done: cover property (@(posedge sys_clk) disable iff (srst) rf_we && kind == OP_LDSH);
   c_stb_req: cover property (@(posedge sys_clk) disable iff (srst) $rose(mem_req) && kind == OP_STB);
   c_sp_load: cover property (@(posedge sys_clk) disable iff (srst)
      rf_we && kind == OP_LDW && rf_sel_base == `HBL_SP_INDEX);
   c_half_imm_store: cover property (@(posedge sys_clk) disable iff (srst)
      $rose(mem_req) && kind == OP_STH && !reg_ofs);

endmodule : hbl_decode

// >>> verilog/hbl_defines.svh
// Encoding constants for the half-word and byte load/store decoder
`ifndef HBL_DEFINES_SVH
`define HBL_DEFINES_SVH
`define HBL_TOP4_REG_OFS   4'h5
`define HBL_TOP3_IMM_OFS   3'h3
`define HBL_TOP4_HALF_IMM  4'h8
`define HBL_TOP4_SP_REL    4'h9
`define HBL_SIGNED_SEL_BIT 9
`define HBL_F8_L_BIT       11
`define HBL_F8_B_BIT       10
`define HBL_F9_B_BIT       12
`define HBL_F9_L_BIT       11
`define HBL_F10_L_BIT      11
`define HBL_RD_LSB         0
`define HBL_RB_LSB         3
`define HBL_RO_LSB         6
`define HBL_OFS5_LSB       6
`define HBL_SP_RD_LSB      8
`define HBL_WORD_SHIFT     2
`define HBL_HALF_SHIFT     1
`define HBL_SP_INDEX       4'hd
`define HBL_WORD_OFS_MAX   32'h0000_03fc
`define HBL_IMM_WORD_MAX   32'h0000_007c
`define HBL_IMM_HALF_MAX   32'h0000_003e
`endif

// >>> verilog/hbl_pkg.sv
// Types shared by the half-word and byte load/store decoder
package hbl_pkg;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_FETCH = 4'b0010,
      ST_MEM   = 4'b0100,
      ST_WB    = 4'b1000
   } hbl_state_type;

   typedef enum logic [2:0] {
      OP_STH  = 3'h0,
      OP_LDH  = 3'h1,
      OP_LDSB = 3'h2,
      OP_LDSH = 3'h3,
      OP_STW  = 3'h4,
      OP_LDW  = 3'h5,
      OP_STB  = 3'h6,
      OP_LDB  = 3'h7
   } hbl_kind_type;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'h0,
      SZ_HALF = 2'h1,
      SZ_WORD = 2'h2
   } hbl_size_type;
endpackage : hbl_pkg
